// file: logic/timer_pkg.sv
package timer_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int SHORT_W = 16;
  localparam int LONG_W = 24;
  // register indices; byte address on the bus is four times the index
  localparam logic [15:0] IDX_B_LOW = 16'h00AC;
  localparam logic [15:0] IDX_B_HIGH = 16'h00AD;
  localparam logic [15:0] IDX_A_LOW = 16'h00AE;
  localparam logic [15:0] IDX_A_HIGH = 16'h00AF;
  localparam logic [15:0] IDX_DUAL_CTRL = 16'h00CF;
  localparam logic [15:0] IDX_L_HIGH = 16'hA063;
  localparam logic [15:0] IDX_L_CTRL = 16'hA068;
  localparam logic [15:0] IDX_L_LOW = 16'hA069;
  localparam logic [15:0] IDX_L_MID = 16'hA06A;
  // dual control field positions; timer a uses the low nibble
  localparam int DUAL_B_BASE = 4;
  localparam int DUAL_A_BASE = 0;
  localparam int NIB_FLAG = 3;
  localparam int NIB_MODE = 2;
  localparam int NIB_RUN = 1;
  localparam int NIB_IE = 0;
  // long timer control field positions
  localparam int L_FLAG = 7;
  localparam int L_SEL_HI = 6;
  localparam int L_SEL_LO = 5;
  localparam int L_MODE = 4;
  localparam int L_RUN = 3;
  localparam int L_IE = 0;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] SEL_RESET = 2'h0;

  typedef struct packed {
    logic flag;
    logic mode;
    logic run;
    logic ie;
  } ctrl_s;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADDR_W-1:0] adr;
    logic [3:0] sel;
    logic [DATA_W-1:0] dat;
  } wb_req_s;
endpackage

// file: logic/reload_free_run_timers.sv
// Overview of operation
// (RULE1) two 16-bit timers clocked by system clock
// (RULE2) dual control: timer b high nibble, a low
// (RULE3) 16-bit overflow sets flag, software writes zero
// (RULE4) 16-bit mode one reloads, zero free-runs
// (RULE5) 16-bit timer counts only while run set
// (RULE6) 16-bit interrupt enable gates overflow interrupt
// (RULE7) 16-bit counter split into low, high bytes
// (RULE8) all counter bytes reset to zero
// (RULE9) 16-bit write: reload value or live counter
// (RULE10) reads return live counter, no snapshot
// (RULE11) software reads highest byte first, low last
// (RULE12) 24-bit timer, free-run or auto-reload
// (RULE13) clock select: fast oscillator 0x, slow 1x
// (RULE14) 24-bit timer independent of system clock
// (RULE15) 24-bit control field layout, bits 2:1 unused
// (RULE16) 24-bit overflow sets flag until cleared
// (RULE17) 24-bit mode one reloads, zero free-runs
// (RULE18) 24-bit timer counts only while run set
// (RULE19) 24-bit interrupt enable gates overflow interrupt
// (RULE20) 24-bit counter in low, mid, high bytes
// (RULE21) 24-bit write: reload value or live counter
// (RULE22) request raised while flag and enable set
// (RULE23) overflow reloads, or wraps to zero
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps

module osc_edge (
  input wire logic mclk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic osc, // asynchronous oscillator pin
  output logic rise // one-cycle pulse per oscillator rise
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= osc;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise = sync_q & ~last_q;
endmodule // osc_edge

module up_timer #(
  parameter int W = 16
) (
  input wire logic mclk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic tick, // count enable pulse
  input wire logic run, // counting allowed
  input wire logic reload_mode, // 1 reload, 0 free-run
  input wire logic [W/8-1:0] wr_en, // byte write strobes
  input wire logic [7:0] wr_byte, // byte write data
  output logic [W-1:0] count, // live counter
  output logic ovf // one-cycle overflow pulse
);
  import timer_pkg::*;
  localparam int NB = W / 8;
  logic [W-1:0] reload_q;
  logic direct_wr;

  // (RULE9) direct load only when free-running
  assign direct_wr = (|wr_en) & ~reload_mode;
  // (RULE5) gated by run bit
  assign ovf = tick & run & (&count) & ~direct_wr;

  // (RULE9) reload mode writes hidden reload
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reload_q <= '0;
    end else begin
      for (int i = 0; i < NB; i++) begin
        if (wr_en[i] && reload_mode) begin
          reload_q[i*8 +: 8] <= wr_byte;
        end
      end
    end
  end

  // (RULE8) counter resets to zero
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      count <= {NB{CNT_RESET}};
    end else if (direct_wr) begin
      for (int i = 0; i < NB; i++) begin
        if (wr_en[i]) begin
          count[i*8 +: 8] <= wr_byte;
        end
      end
    end else if (tick && run) begin
      // (RULE23) reload or wrap on overflow
      if (&count) begin
        count <= reload_mode ? reload_q : '0;
      end else begin
        count <= count + 1'b1;
      end
    end
  end
endmodule // up_timer

module reload_free_run_timers (
  input wire logic mclk, // system clock, 100 MHz
  input wire logic rstn, // async reset, active low
  input wire timer_pkg::wb_req_s req, // wishbone request
  input wire logic fast_internal_oscillator, // fast oscillator pin
  input wire logic slow_internal_oscillator, // slow oscillator pin
  output logic [timer_pkg::DATA_W-1:0] rdata, // wishbone read data
  output logic ack, // wishbone acknowledge
  output logic timer_a_irq, // timer a interrupt request
  output logic timer_b_irq, // timer b interrupt request
  output logic long_timer_irq // long timer interrupt request
);
  import timer_pkg::*;

  logic [15:0] idx;
  logic take;
  logic wr;
  logic [7:0] wdat;
  logic [7:0] rbyte;
  ctrl_s ta_q;
  ctrl_s tb_q;
  ctrl_s tl_q;
  logic [1:0] long_timer_clock_select_q;
  logic [SHORT_W-1:0] timer_a_counter;
  logic [SHORT_W-1:0] timer_b_counter;
  logic [LONG_W-1:0] long_timer_counter;
  logic ovf_a;
  logic ovf_b;
  logic ovf_l;
  logic fast_rise;
  logic slow_rise;
  logic long_tick;
  logic wr_dual;
  logic wr_lctrl;

  assign idx = req.adr[ADDR_W-1:2];
  // a request is taken in the cycle before the ack is high
  assign take = req.cyc & req.stb & ~ack;
  assign wr = take & req.we & req.sel[0];
  assign wdat = req.dat[7:0];
  assign wr_dual = wr && (idx == IDX_DUAL_CTRL);
  assign wr_lctrl = wr && (idx == IDX_L_CTRL);

  osc_edge fast_sync (
    .mclk(mclk),
    .rstn(rstn),
    .osc(fast_internal_oscillator),
    .rise(fast_rise)
  );

  osc_edge slow_sync (
    .mclk(mclk),
    .rstn(rstn),
    .osc(slow_internal_oscillator),
    .rise(slow_rise)
  );

  // (RULE13) select oscillator by upper select bit
  assign long_tick = long_timer_clock_select_q[1] ? slow_rise : fast_rise;

  // (RULE1) system clock drives short timers every cycle
  up_timer #(.W(SHORT_W)) timer_a (
    .mclk(mclk),
    .rstn(rstn),
    .tick(1'b1),
    .run(ta_q.run),
    .reload_mode(ta_q.mode),
    .wr_en({wr && (idx == IDX_A_HIGH), wr && (idx == IDX_A_LOW)}),
    .wr_byte(wdat),
    .count(timer_a_counter),
    .ovf(ovf_a)
  );

  up_timer #(.W(SHORT_W)) timer_b (
    .mclk(mclk),
    .rstn(rstn),
    .tick(1'b1),
    .run(tb_q.run),
    .reload_mode(tb_q.mode),
    .wr_en({wr && (idx == IDX_B_HIGH), wr && (idx == IDX_B_LOW)}),
    .wr_byte(wdat),
    .count(timer_b_counter),
    .ovf(ovf_b)
  );

  // (RULE12) 24-bit timer, rate set by the oscillator tick
  // (RULE14) oscillator edges alone advance it; mclk only samples them
  up_timer #(.W(LONG_W)) long_timer (
    .mclk(mclk),
    .rstn(rstn),
    .tick(long_tick),
    .run(tl_q.run),
    .reload_mode(tl_q.mode),
    .wr_en({wr && (idx == IDX_L_HIGH), wr && (idx == IDX_L_MID),
            wr && (idx == IDX_L_LOW)}),
    .wr_byte(wdat),
    .count(long_timer_counter),
    .ovf(ovf_l)
  );

  // (RULE2) dual control write, mode/run/enable
  // (RULE4) mode bit steers timer
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ta_q.mode <= 1'b0;
      ta_q.run <= 1'b0;
      ta_q.ie <= 1'b0;
      tb_q.mode <= 1'b0;
      tb_q.run <= 1'b0;
      tb_q.ie <= 1'b0;
    end else if (wr_dual) begin
      ta_q.mode <= wdat[DUAL_A_BASE + NIB_MODE];
      ta_q.run <= wdat[DUAL_A_BASE + NIB_RUN];
      ta_q.ie <= wdat[DUAL_A_BASE + NIB_IE];
      tb_q.mode <= wdat[DUAL_B_BASE + NIB_MODE];
      tb_q.run <= wdat[DUAL_B_BASE + NIB_RUN];
      tb_q.ie <= wdat[DUAL_B_BASE + NIB_IE];
    end
  end

  // (RULE3) flags: overflow sets, written zero clears, set wins
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ta_q.flag <= 1'b0;
      tb_q.flag <= 1'b0;
    end else begin
      if (ovf_a) begin
        ta_q.flag <= 1'b1;
      end else if (wr_dual && !wdat[DUAL_A_BASE + NIB_FLAG]) begin
        ta_q.flag <= 1'b0;
      end
      if (ovf_b) begin
        tb_q.flag <= 1'b1;
      end else if (wr_dual && !wdat[DUAL_B_BASE + NIB_FLAG]) begin
        tb_q.flag <= 1'b0;
      end
    end
  end

  // (RULE15) long control layout
  // (RULE17) long mode bit
  // (RULE18) long run bit
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tl_q.mode <= 1'b0;
      tl_q.run <= 1'b0;
      tl_q.ie <= 1'b0;
      long_timer_clock_select_q <= SEL_RESET;
    end else if (wr_lctrl) begin
      tl_q.mode <= wdat[L_MODE];
      tl_q.run <= wdat[L_RUN];
      tl_q.ie <= wdat[L_IE];
      long_timer_clock_select_q <= wdat[L_SEL_HI:L_SEL_LO];
    end
  end

  // (RULE16) long flag sticky, set beats clear
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tl_q.flag <= 1'b0;
    end else if (ovf_l) begin
      tl_q.flag <= 1'b1;
    end else if (wr_lctrl && !wdat[L_FLAG]) begin
      tl_q.flag <= 1'b0;
    end
  end

  // (RULE6) short enables gate the request
  // (RULE19) long enable gates the request
  // (RULE22) request follows flag and enable
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      timer_a_irq <= 1'b0;
      timer_b_irq <= 1'b0;
      long_timer_irq <= 1'b0;
    end else begin
      timer_a_irq <= ta_q.flag & ta_q.ie;
      timer_b_irq <= tb_q.flag & tb_q.ie;
      long_timer_irq <= tl_q.flag & tl_q.ie;
    end
  end

  // (RULE7) short counter byte lanes
  // (RULE20) long counter byte lanes
  // (RULE10) live counter, nothing latched on read
  always_comb begin
    unique case (idx)
      IDX_A_LOW: rbyte = timer_a_counter[7:0];
      IDX_A_HIGH: rbyte = timer_a_counter[15:8];
      IDX_B_LOW: rbyte = timer_b_counter[7:0];
      IDX_B_HIGH: rbyte = timer_b_counter[15:8];
      IDX_DUAL_CTRL: rbyte = {tb_q, ta_q};
      IDX_L_LOW: rbyte = long_timer_counter[7:0];
      IDX_L_MID: rbyte = long_timer_counter[15:8];
      IDX_L_HIGH: rbyte = long_timer_counter[23:16];
      IDX_L_CTRL: rbyte = {tl_q.flag, long_timer_clock_select_q, tl_q.mode,
                           tl_q.run, 2'h0, tl_q.ie};
      default: rbyte = CTRL_RESET;
    endcase
  end

  // one wait state: ack one cycle after the request appears, then low
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ack <= 1'b0;
      rdata <= '0;
    end else begin
      ack <= take;
      if (take) begin
        rdata <= {24'h000000, rbyte};
      end
    end
  end
endmodule // reload_free_run_timers

// file: tb/timer_assertions.sv
`timescale 1ns/1ps
module timer_assertions (
  input wire logic mclk, // system clock
  input wire logic rstn, // async reset, active low
  input wire timer_pkg::wb_req_s req, // bus request
  input wire logic fast_internal_oscillator, // fast pin
  input wire logic slow_internal_oscillator, // slow pin
  input wire logic [timer_pkg::DATA_W-1:0] rdata, // read data
  input wire logic ack, // acknowledge
  input wire logic timer_a_irq, // timer a request
  input wire logic timer_b_irq, // timer b request
  input wire logic long_timer_irq // long timer request
);
  import timer_pkg::*;
  localparam logic [17:0] DUAL_ADR = {IDX_DUAL_CTRL, 2'h0};
  localparam logic [17:0] LONG_ADR = {IDX_L_CTRL, 2'h0};
  logic take;
  logic wr0;
  assign take = req.cyc & req.stb & ~ack;
  assign wr0 = take & req.we & req.sel[0];
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("ack held past one cycle");
  a_ack_answer: assert property (take |=> ack)
    else $error("request not answered next cycle");
  a_ack_cause: assert property (ack |-> $past(take))
    else $error("ack without request");
  a_rdata_hold: assert property (!ack |-> $stable(rdata))
    else $error("read data moved without ack");
  a_rdata_byte: assert property (rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_ie_blocks_a: assert property (wr0 && req.adr == DUAL_ADR && !req.dat[0] |-> ##2 !timer_a_irq)
    else $error("timer a request with enable off");
  a_ie_blocks_b: assert property (wr0 && req.adr == DUAL_ADR && !req.dat[4] |-> ##2 !timer_b_irq)
    else $error("timer b request with enable off");
  a_ie_blocks_l: assert property (wr0 && req.adr == LONG_ADR && !req.dat[0] |-> ##2 !long_timer_irq)
    else $error("long timer request with enable off");
  c_a_irq: cover property (timer_a_irq);
  c_l_irq: cover property (long_timer_irq);
  c_ctrl_wr: cover property (wr0 && req.adr == DUAL_ADR);
endmodule // timer_assertions

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import timer_pkg::*;
  localparam logic [17:0] AL = {IDX_A_LOW, 2'h0};
  localparam logic [17:0] AH = {IDX_A_HIGH, 2'h0};
  localparam logic [17:0] BL = {IDX_B_LOW, 2'h0};
  localparam logic [17:0] BH = {IDX_B_HIGH, 2'h0};
  localparam logic [17:0] DC = {IDX_DUAL_CTRL, 2'h0};
  localparam logic [17:0] LL = {IDX_L_LOW, 2'h0};
  localparam logic [17:0] LM = {IDX_L_MID, 2'h0};
  localparam logic [17:0] LH = {IDX_L_HIGH, 2'h0};
  localparam logic [17:0] LC = {IDX_L_CTRL, 2'h0};
  logic [17:0] regs [9] = '{AL, AH, BL, BH, DC, LL, LM, LH, LC};
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  wb_req_s req = '0;
  logic fast_osc = 1'b0;
  logic slow_osc = 1'b0;
  logic [3:0] div_q = 4'h0;
  logic [DATA_W-1:0] rdata;
  logic ack;
  logic a_irq;
  logic b_irq;
  logic l_irq;
  logic [7:0] v;
  int err_total = 0;
  int tests_run = 0;
  always #5 mclk = ~mclk;
  // oscillators at a quarter and a sixteenth of mclk keep the selects apart
  always @(posedge mclk) begin
    div_q <= div_q + 4'h1;
    fast_osc <= div_q[1];
    slow_osc <= div_q[3];
  end
  reload_free_run_timers reload_free_run_timers_i (.mclk(mclk), .rstn(rstn), .req(req),
    .fast_internal_oscillator(fast_osc), .slow_internal_oscillator(slow_osc),
    .rdata(rdata), .ack(ack), .timer_a_irq(a_irq), .timer_b_irq(b_irq),
    .long_timer_irq(l_irq));
  task automatic bus(input logic [17:0] a, input logic w, input logic [7:0] d,
                     output logic [7:0] q);
    int n = 0;
    req <= '{1'b1, 1'b1, w, a, 4'hF, {24'h0, d}};
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdata[7:0];
    if (n >= 20) begin
      err_total++;
      $display("BAD %0t no ack at %h", $time, a);
    end
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] e);
    tests_run++;
    if (got !== e) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, e);
    end
  endtask
  task automatic chk(input logic [17:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(a, 1'b0, 8'h00, q);
    cmp(q, e);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    foreach (regs[i]) chk(regs[i], 8'h00);
    wr(18'h00400, 8'h5A);
    chk(18'h00400, 8'h00);
    $display("test reset done");
    wr(AL, 8'hF0);
    wr(AH, 8'hFF);
    chk(AH, 8'hFF);
    chk(AL, 8'hF0);
    wr(DC, 8'h03);
    repeat (30) @(posedge mclk);
    cmp({7'h0, a_irq}, 8'h01);
    chk(AH, 8'h00);
    wr(DC, 8'h0B);
    chk(DC, 8'h0B);
    wr(DC, 8'h01);
    chk(DC, 8'h01);
    cmp({7'h0, a_irq}, 8'h00);
    bus(AL, 1'b0, 8'h00, v);
    repeat (10) @(posedge mclk);
    chk(AL, v);
    $display("test timer a done");
    wr(DC, 8'h40);
    wr(BL, 8'h34);
    wr(BH, 8'hFF);
    chk(BH, 8'h00);
    wr(DC, 8'h00);
    wr(BL, 8'hF0);
    wr(BH, 8'hFF);
    wr(DC, 8'h60);
    repeat (30) @(posedge mclk);
    chk(BH, 8'hFF);
    chk(DC, 8'hE0);
    cmp({7'h0, b_irq}, 8'h00);
    wr(DC, 8'h00);
    $display("test timer b done");
    wr(LL, 8'hFE);
    wr(LM, 8'hFF);
    wr(LH, 8'hFF);
    wr(LC, 8'h09);
    repeat (40) @(posedge mclk);
    cmp({7'h0, l_irq}, 8'h01);
    chk(LC, 8'h89);
    chk(LH, 8'h00);
    wr(LC, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(LL, 8'h00);
      wr(LC, {1'b0, s[1:0], 5'h08});
      repeat (48) @(posedge mclk);
      wr(LC, {1'b0, s[1:0], 5'h00});
      bus(LL, 1'b0, 8'h00, v);
      cmp({7'h0, v >= (s[1] ? 2 : 10) && v <= (s[1] ? 6 : 14)}, 8'h01);
      repeat (20) @(posedge mclk);
      chk(LL, v);
    end
    // reload mode: byte writes land in the hidden reload word only
    wr(LC, 8'h10);
    wr(LL, 8'h20);
    wr(LM, 8'hAB);
    wr(LH, 8'h00);
    chk(LM, 8'h00);
    wr(LC, 8'h00);
    wr(LL, 8'hFE);
    wr(LM, 8'hFF);
    wr(LH, 8'hFF);
    wr(LC, 8'h18);
    repeat (40) @(posedge mclk);
    chk(LM, 8'hAB);
    chk(LC, 8'h98);
    cmp({7'h0, l_irq}, 8'h00);
    wr(LC, 8'h00);
    $display("test long timer done");
    results;
  end
  // the tests need about 650 cycles; the 10000-cycle limit, some fifteen times that, means a hang
  initial begin
    #100000;
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    results;
  end
endmodule // tb_top
bind reload_free_run_timers timer_assertions timer_assertions_i (.mclk(mclk), .rstn(rstn),
  .req(req), .fast_internal_oscillator(fast_internal_oscillator),
  .slow_internal_oscillator(slow_internal_oscillator), .rdata(rdata), .ack(ack),
  .timer_a_irq(timer_a_irq), .timer_b_irq(timer_b_irq), .long_timer_irq(long_timer_irq));
